// *** hw/plth_defs.svh ***
// Constants for the pulse length timer with hysteresis output
//=============================================================
// Overview of operation
// RULE1: Mode word: opcode, resolution, output, type, relation
// RULE2: Resolution code 01 means 2 ms per count
// RULE3: Output enable drives switch from relation result
// RULE4: Type 1 measures input pulse length
// RULE5: Relation 110 is below-initial with hysteresis
// RULE6: Controller gives limits in resolution units
// RULE7: Command 2800 hex restores default configuration
// RULE8: Commands 4000/5000 hex load initial/final limit
// RULE9: Command echoed in first input word
// RULE10: Read counter: upper echo, count in word two
// RULE11: Controller multiplies count by resolution
// RULE12: Measurement starts right after mode command
// RULE13: Below final limit, output stays one
// RULE14: Reaching final limit switches output to zero
// RULE15: Falling to initial limit switches output back
// RULE16: Count reads optional, output runs independently
// RULE17: Mode fields held until next mode/default
`ifndef PLTH_DEFS_SVH
`define PLTH_DEFS_SVH

//=============================================================
// Register word indices (byte address = index * 4)
`define PLTH_IDX_CMD     3'h0
`define PLTH_IDX_PARAM   3'h1
`define PLTH_IDX_ECHO    3'h2
`define PLTH_IDX_DATA    3'h3
`define PLTH_IDX_STATUS  3'h4

//=============================================================
// Command opcodes, bits 15..10 of the command word
`define PLTH_OP_HI       15
`define PLTH_OP_LO       10
`define PLTH_OP_READ     6'h00
`define PLTH_OP_MODE     6'h06
`define PLTH_OP_DEFAULT  6'h0A
`define PLTH_OP_PRE_INIT 6'h10
`define PLTH_OP_PRE_FIN  6'h14

//=============================================================
// Mode word fields
`define PLTH_F_RES_HI    7
`define PLTH_F_RES_LO    6
`define PLTH_F_OUT       5
`define PLTH_F_TYPE      4
`define PLTH_F_REL_HI    2
`define PLTH_F_REL_LO    0
`define PLTH_REL_GE_INIT 3'h1
`define PLTH_REL_HYST    3'h6
`define PLTH_ECHO_REL    9

//=============================================================
// Reset values
`define PLTH_CMD_RST     16'h0000
`define PLTH_LIM_RST     16'h0000

//=============================================================
// Timing: clock rate and resolution per code
`define PLTH_CLK_HZ      40000000
`define PLTH_RES0_US     1000
`define PLTH_RES1_US     2000
`define PLTH_RES2_US     10000
`define PLTH_RES3_US     100000
`define PLTH_US_CYC(us)  ((`PLTH_CLK_HZ / 1000000) * (us))

`endif

// *** hw/plth_pkg.sv ***
// Types and command decoding for the pulse length timer
`include "plth_defs.svh"

package plth_pkg;

   //==========================================================
   // Command classes
   typedef enum logic [2:0] {
      PLTH_CMD_READ,
      PLTH_CMD_MODE,
      PLTH_CMD_DEFAULT,
      PLTH_CMD_PRE_INIT,
      PLTH_CMD_PRE_FIN,
      PLTH_CMD_OTHER
   } plth_cmd_t;

   // Measurement states
   typedef enum logic [1:0] {
      PLTH_MS_IDLE,
      PLTH_MS_ARM,
      PLTH_MS_RUN
   } plth_meas_t;

   function automatic plth_cmd_t plth_decode(input logic [15:0] word);
      logic [5:0] op;
      op = word[`PLTH_OP_HI:`PLTH_OP_LO];
      case (op)
         `PLTH_OP_READ:     plth_decode = PLTH_CMD_READ;
         `PLTH_OP_MODE:     plth_decode = PLTH_CMD_MODE;
         `PLTH_OP_DEFAULT:  plth_decode = PLTH_CMD_DEFAULT;
         `PLTH_OP_PRE_INIT: plth_decode = PLTH_CMD_PRE_INIT;
         `PLTH_OP_PRE_FIN:  plth_decode = PLTH_CMD_PRE_FIN;
         default:           plth_decode = PLTH_CMD_OTHER;
      endcase
   endfunction : plth_decode

endpackage : plth_pkg

// *** hw/plth_tick.sv ***
// Resolution prescaler: one tick per count unit
`timescale 1ns/1ps
`include "plth_defs.svh"

module plth_tick
   import plth_pkg::*;
#(
   parameter int unsigned TICK0_CYC = `PLTH_US_CYC(`PLTH_RES0_US),
   parameter int unsigned TICK1_CYC = `PLTH_US_CYC(`PLTH_RES1_US),
   parameter int unsigned TICK2_CYC = `PLTH_US_CYC(`PLTH_RES2_US),
   parameter int unsigned TICK3_CYC = `PLTH_US_CYC(`PLTH_RES3_US)
)
(
   // Clock and control
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       restart_i,
   // Resolution select
   input  wire logic [1:0] res_i,
   // Tick out
   output logic            tick_o
);

   if (TICK0_CYC < 2 || TICK1_CYC < 2 || TICK2_CYC < 2 || TICK3_CYC < 2)
   begin : g_chk
      $error("plth_tick: tick periods must be at least 2 cycles");
   end

   logic [31:0] cnt;
   wire  [31:0] period;
   wire         wrap;

   assign period = (res_i == 2'h0) ? TICK0_CYC :
                   (res_i == 2'h1) ? TICK1_CYC : // [RULE2]
                   (res_i == 2'h2) ? TICK2_CYC : TICK3_CYC;
   assign wrap   = (cnt >= period - 32'h1);

   always_ff @(posedge clk_i)
   begin
      if (rst_i || (ce_i && restart_i))
      begin
         cnt    <= 32'h0;
         tick_o <= 1'b0;
      end
      else if (ce_i)
      begin
         cnt    <= wrap ? 32'h0 : cnt + 32'h1;
         tick_o <= wrap;
      end
   end

   //==========================================================
   // Checks
   property p_tick_gap;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && tick_o) |=> !tick_o;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("tick high two cycles running");

   property p_tick_2ms;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && !restart_i && res_i == 2'h1 && cnt == TICK1_CYC - 1)
      |=> (tick_o && cnt == 32'h0);
   endproperty
   a_tick_2ms: assert property (p_tick_2ms) // [RULE2]
      else $error("2 ms unit not ticked at its period");

endmodule : plth_tick

// *** hw/plth_meas.sv ***
// Pulse length / period measurement in count units
`timescale 1ns/1ps
`include "plth_defs.svh"

module plth_meas
   import plth_pkg::*;
#(
   parameter int unsigned W = 16
)
(
   // Clock and control
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic         start_i,
   input  wire logic         stop_i,
   input  wire logic         type_i,
   input  wire logic         tick_i,
   // Measured signal
   input  wire logic         sig_i,
   // Result
   output logic [W-1:0]      len_o,
   output logic              len_vld_o,
   output logic              busy_o
);

   plth_meas_t  state;
   plth_meas_t  next_state;
   logic          sig_q;
   logic [W-1:0]  acc;
   wire           rise;
   wire           fall;
   wire           done;
   wire  [W-1:0]  acc_inc;

   assign rise    = sig_i && !sig_q;
   assign fall    = !sig_i && sig_q;
   // Pulse type ends on the falling edge, period type on the next rising
   assign done    = (state == PLTH_MS_RUN) && (type_i ? fall : rise); // [RULE4]
   // Saturate rather than wrap so an overlong pulse never reads short
   assign acc_inc = (&acc) ? acc : acc + {{(W-1){1'b0}}, 1'b1};

   always_comb
   begin
      next_state = state;
      case (state)
         PLTH_MS_IDLE: next_state = PLTH_MS_IDLE;
         PLTH_MS_ARM:  if (rise) next_state = PLTH_MS_RUN;
         PLTH_MS_RUN:  if (done && type_i) next_state = PLTH_MS_ARM;
         default:      next_state = PLTH_MS_IDLE;
      endcase
      if (stop_i)
         next_state = PLTH_MS_IDLE;
      else if (start_i)
         next_state = PLTH_MS_ARM; // [RULE12]
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state     <= PLTH_MS_IDLE;
         sig_q     <= 1'b0;
         acc       <= '0;
         len_o     <= '0;
         len_vld_o <= 1'b0;
      end
      else if (ce_i)
      begin
         state     <= next_state;
         sig_q     <= sig_i;
         len_vld_o <= done && !start_i && !stop_i;
         if (done)
            len_o <= acc;
         if (start_i || stop_i || rise)
            acc <= '0;
         else if (tick_i)
            acc <= acc_inc;
      end
   end

   assign busy_o = (state != PLTH_MS_IDLE);

   //==========================================================
   // Checks
   property p_start;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && start_i && !stop_i) |=> (state == PLTH_MS_ARM);
   endproperty
   a_start: assert property (p_start) // [RULE12]
      else $error("measurement not armed after mode command");

   property p_pulse_end;
      @(posedge clk_i) disable iff (rst_i)
      (len_vld_o && type_i && !$past(start_i)) |->
         ($past(sig_q) && !$past(sig_i));
   endproperty
   a_pulse_end: assert property (p_pulse_end) // [RULE4]
      else $error("pulse length result not at falling edge");

endmodule : plth_meas

// *** hw/plth_top.sv ***
// Pulse length timer with hysteresis switch, Wishbone slave
`timescale 1ns/1ps
`include "plth_defs.svh"

module plth_top
   import plth_pkg::*;
#(
   parameter int unsigned W         = 16,
   parameter int unsigned TICK0_CYC = `PLTH_US_CYC(`PLTH_RES0_US),
   parameter int unsigned TICK1_CYC = `PLTH_US_CYC(`PLTH_RES1_US),
   parameter int unsigned TICK2_CYC = `PLTH_US_CYC(`PLTH_RES2_US),
   parameter int unsigned TICK3_CYC = `PLTH_US_CYC(`PLTH_RES3_US)
)
(
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Measured input and switching output
   input  wire logic        sig_i,
   output logic             switch_o
);

   if (W != 16)
   begin : g_chk
      $error("plth_top: only a 16-bit count is supported");
   end

   //==========================================================
   // Bus decode
   logic [15:0] cmd_word;
   logic [15:0] par_word;
   logic [15:0] echo;
   logic [15:0] data;
   wire  [15:0] cmd_new;
   wire  [15:0] par_new;
   wire         bus_req;
   wire         wr_take;
   wire         wr_cmd;
   wire         wr_par;
   wire  [2:0]  idx;
   wire         mapped;
   plth_cmd_t   op;

   assign bus_req = wb_cyc_i && wb_stb_i;
   // Write lands at the edge where the master sees ack
   assign wr_take = bus_req && wb_ack_o && wb_we_i;
   assign idx     = wb_adr_i[4:2];
   assign mapped  = (wb_adr_i[7:5] == 3'h0) && (idx <= `PLTH_IDX_STATUS);
   assign wr_cmd  = wr_take && mapped && (idx == `PLTH_IDX_CMD);
   assign wr_par  = wr_take && mapped && (idx == `PLTH_IDX_PARAM);

   for (genvar b = 0; b < 2; b++)
   begin : g_lane
      assign cmd_new[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8]
                                             : cmd_word[b*8 +: 8];
      assign par_new[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8]
                                             : par_word[b*8 +: 8];
   end

   assign op = plth_decode(cmd_new);

   //==========================================================
   // Configuration
   logic [1:0]   cfg_res;
   logic         cfg_out;
   logic         cfg_type;
   logic [2:0]   cfg_rel;
   logic [15:0]  lim_init;
   logic [15:0]  lim_fin;
   wire          do_mode;
   wire          do_dflt;

   assign do_mode = ce_i && wr_cmd && (op == PLTH_CMD_MODE);
   assign do_dflt = ce_i && wr_cmd && (op == PLTH_CMD_DEFAULT);

   always_ff @(posedge clk_i)
   begin
      if (rst_i || do_dflt) // [RULE7]
      begin
         cfg_res  <= 2'h0;
         cfg_out  <= 1'b0;
         cfg_type <= 1'b0;
         cfg_rel  <= 3'h0;
         lim_init <= `PLTH_LIM_RST;
         lim_fin  <= `PLTH_LIM_RST;
      end
      else if (ce_i && wr_cmd)
      begin
         if (op == PLTH_CMD_MODE) // [RULE1] [RULE17]
         begin
            cfg_res  <= cmd_new[`PLTH_F_RES_HI:`PLTH_F_RES_LO];
            cfg_out  <= cmd_new[`PLTH_F_OUT];
            cfg_type <= cmd_new[`PLTH_F_TYPE];
            cfg_rel  <= cmd_new[`PLTH_F_REL_HI:`PLTH_F_REL_LO];
         end
         // Limits are raw count units; the controller scales them
         if (op == PLTH_CMD_PRE_INIT)
            lim_init <= par_word; // [RULE8] [RULE6]
         if (op == PLTH_CMD_PRE_FIN)
            lim_fin <= par_word; // [RULE8]
      end
   end

   //==========================================================
   // Timebase and measurement
   wire          tick;
   wire [15:0]   len;
   wire          len_vld;
   wire          busy;

   plth_tick #(
      .TICK0_CYC (TICK0_CYC),
      .TICK1_CYC (TICK1_CYC),
      .TICK2_CYC (TICK2_CYC),
      .TICK3_CYC (TICK3_CYC)
   ) u_tick (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .restart_i (do_mode),
      .res_i     (cfg_res),
      .tick_o    (tick)
   );

   plth_meas #(
      .W         (W)
   ) u_meas (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .start_i   (do_mode),
      .stop_i    (do_dflt),
      .type_i    (cfg_type),
      .tick_i    (tick),
      .sig_i     (sig_i),
      .len_o     (len),
      .len_vld_o (len_vld),
      .busy_o    (busy)
   );

   //==========================================================
   // Relation condition
   logic         hyst;
   logic         next_hyst;
   wire          rel_res;

   // Hysteresis: high until the final limit, low until back at initial
   always_comb
   begin
      next_hyst = hyst;
      if (len_vld)
      begin
         if (len >= lim_fin)
            next_hyst = 1'b0; // [RULE14]
         else if (len <= lim_init)
            next_hyst = 1'b1; // [RULE15]
      end
   end

   assign rel_res = (cfg_rel == `PLTH_REL_HYST)    ? hyst : // [RULE5]
                    (cfg_rel == `PLTH_REL_GE_INIT) ? (len >= lim_init) :
                    1'b0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i || do_mode || do_dflt)
         hyst <= 1'b1; // [RULE13]
      else if (ce_i)
         hyst <= next_hyst;
   end

   //==========================================================
   // Process words and switching output
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cmd_word <= `PLTH_CMD_RST;
         par_word <= 16'h0000;
         echo     <= `PLTH_CMD_RST;
         data     <= 16'h0000;
         switch_o <= 1'b0;
      end
      else if (ce_i)
      begin
         switch_o <= cfg_out && rel_res; // [RULE3] [RULE16]
         if (wr_par)
            par_word <= par_new;
         if (wr_cmd)
         begin
            cmd_word <= cmd_new;
            if (op == PLTH_CMD_READ) // [RULE10]
            begin
               echo <= {cmd_new[`PLTH_OP_HI:`PLTH_OP_LO], rel_res, 9'h000};
               data <= len;
            end
            else
            begin
               echo <= cmd_new; // [RULE9]
               if (op == PLTH_CMD_PRE_INIT || op == PLTH_CMD_PRE_FIN)
                  data <= par_word;
            end
         end
      end
   end

   //==========================================================
   // Wishbone answer: one wait state, ack dropped after one cycle
   wire [31:0] rd_mux;

   assign rd_mux = !mapped                      ? 32'h0000_0000 :
                   (idx == `PLTH_IDX_CMD)       ? {16'h0000, cmd_word} :
                   (idx == `PLTH_IDX_PARAM)     ? {16'h0000, par_word} :
                   (idx == `PLTH_IDX_ECHO)      ? {16'h0000, echo} :
                   (idx == `PLTH_IDX_DATA)      ? {16'h0000, data} :
                   {29'h0, busy, rel_res, switch_o};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         wb_ack_o <= bus_req && !wb_ack_o;
         wb_dat_o <= (bus_req && !wb_ack_o && !wb_we_i) ? rd_mux
                                                        : 32'h0000_0000;
      end
   end

   //==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_echo;
      (ce_i && wr_cmd && op != PLTH_CMD_READ) |=> (echo == $past(cmd_new));
   endproperty
   a_echo: assert property (p_echo) // [RULE9]
      else $error("command word not echoed");

   property p_read;
      (ce_i && wr_cmd && op == PLTH_CMD_READ) |=>
         (echo[15:10] == $past(cmd_new[15:10]) && data == $past(len));
   endproperty
   a_read: assert property (p_read) // [RULE10]
      else $error("read counter answer wrong");

   property p_mode;
      do_mode |=> (cfg_res == $past(cmd_new[7:6]) &&
                   cfg_out == $past(cmd_new[5]) &&
                   cfg_type == $past(cmd_new[4]) &&
                   cfg_rel == $past(cmd_new[2:0]));
   endproperty
   a_mode: assert property (p_mode) // [RULE17]
      else $error("mode fields not stored");

   property p_dflt;
      do_dflt |=> (!cfg_out && cfg_rel == 3'h0 && lim_fin == 16'h0000 &&
                   !busy);
   endproperty
   a_dflt: assert property (p_dflt) // [RULE7]
      else $error("default command did not restore defaults");

   property p_preset;
      (ce_i && wr_cmd && op == PLTH_CMD_PRE_FIN) |=>
         (lim_fin == $past(par_word) && data == $past(par_word));
   endproperty
   a_preset: assert property (p_preset) // [RULE8]
      else $error("final limit not loaded");

   property p_hyst_off;
      (ce_i && len_vld && !wr_cmd && cfg_rel == `PLTH_REL_HYST &&
       len >= lim_fin) ##1 ce_i |=> !switch_o;
   endproperty
   a_hyst_off: assert property (p_hyst_off) // [RULE14]
      else $error("switch not off at final limit");

   property p_hyst_on;
      (ce_i && len_vld && !wr_cmd && cfg_rel == `PLTH_REL_HYST &&
       len < lim_fin && len <= lim_init) ##1 (ce_i && !wr_cmd)
       |=> (switch_o == $past(cfg_out));
   endproperty
   a_hyst_on: assert property (p_hyst_on) // [RULE15]
      else $error("switch not back on at initial limit");

   property p_hyst_hold;
      (ce_i && len_vld && !wr_cmd && len < lim_fin && len > lim_init)
      |=> (hyst == $past(hyst));
   endproperty
   a_hyst_hold: assert property (p_hyst_hold) // [RULE13]
      else $error("hysteresis state moved inside the band");

   property p_ack_drop;
      (ce_i && wb_ack_o) |=> !wb_ack_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack held longer than one cycle");

   c_mode: cover property (do_mode ##[1:200] len_vld);
   c_off:  cover property (len_vld && cfg_rel == `PLTH_REL_HYST && !hyst);
   c_read: cover property (ce_i && wr_cmd && op == PLTH_CMD_READ);

endmodule : plth_top

// *** test/plth_pulse_src.sv ***
// Pulse source standing in for the sensor on the measured input
`timescale 1ns/1ps

module plth_pulse_src
(
   // Clock
   input  wire logic clk_i,
   // Measured line
   output logic      sig_o
);
   //==========================================================
   // Pulse generation
   initial sig_o = 1'b0;

   // High for hi cycles, then low for lo cycles; edges follow the clock
   // so the design never sees a half-cycle glitch.
   task automatic pulse(input int unsigned hi, input int unsigned lo);
      @(posedge clk_i);
      sig_o <= 1'b1;
      repeat (hi) @(posedge clk_i);
      sig_o <= 1'b0;
      repeat (lo) @(posedge clk_i);
   endtask : pulse

endmodule : plth_pulse_src

// *** test/tb_top.sv ***
// Self-checking bench for the pulse length timer
`timescale 1ns/1ps

module tb_top;
   //==========================================================
   // Constants: one count unit at resolution 01 is 8 clocks here
   localparam int unsigned UNIT  = 8;
   localparam logic [7:0]  A_CMD = 8'h00;
   localparam logic [7:0]  A_PAR = 8'h04;
   localparam logic [7:0]  A_ECH = 8'h08;
   localparam logic [7:0]  A_DAT = 8'h0C;
   localparam logic [7:0]  A_STA = 8'h10;

   //==========================================================
   // Design signals
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i  = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        sig;
   logic        switch_o;
   int          err_count   = 0;
   int          comparisons = 0;

   always #12.5 clk_i = ~clk_i;

   plth_top #(.W(16), .TICK0_CYC(4), .TICK1_CYC(UNIT), .TICK2_CYC(16), .TICK3_CYC(32))
   dut_u (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .wb_cyc_i(cyc),
      .wb_stb_i(stb),
      .wb_we_i (we),
      .wb_adr_i(adr),
      .wb_sel_i(sel),
      .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .sig_i   (sig),
      .switch_o(switch_o)
   );

   plth_pulse_src src_u (
      .clk_i(clk_i),
      .sig_o(sig)
   );

   //==========================================================
   // Checking and closing
   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_eq

   task automatic check_rng(input logic [31:0] got, input int lo, input int hi);
      comparisons++;
      if ((^got === 1'bx) || (got < lo) || (got > hi))
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : check_rng

   task automatic report_and_stop;
      $display("errors=%0d comparisons=%0d", err_count, comparisons);
      if ((err_count == 0) && (comparisons > 0))
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   //==========================================================
   // Wishbone classic master: waits for ack, no fixed latency assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] rd);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'hF;
      wdat <= {16'h0, d};
      @(posedge clk_i);
      // Only the watchdog ends a wait that never sees ack
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      wb(1'b0, a, 16'h0, r);
      check_eq(r, exp);
   endtask : rd_chk

   // Parameter first, then command, then one read of its echo, checked
   task automatic cmd(input logic [15:0] c, input logic [15:0] p);
      logic [31:0] r;
      wb(1'b1, A_PAR, p, r);
      wb(1'b1, A_CMD, c, r);
      rd_chk(A_ECH, {16'h0, c});
   endtask : cmd

   // Pulse of n units, a quiet gap, then the output level is judged
   task automatic pulse_sw(input int unsigned n, input logic exp);
      src_u.pulse(n * UNIT, 4 * UNIT);
      check_eq({31'h0, switch_o}, {31'h0, exp});
   endtask : pulse_sw

   //==========================================================
   // Scenarios
   task automatic t_reset;
      logic [31:0] r;
      check_eq({31'h0, switch_o}, 32'h0);
      rd_chk(A_ECH, 32'h0);
      rd_chk(A_DAT, 32'h0);
      wb(1'b1, 8'hE0, 16'hFFFF, r);
      rd_chk(8'hE0, 32'h0);
      rd_chk(A_CMD, 32'h0);
   endtask : t_reset

   task automatic t_program;
      cmd(16'h2800, 16'h0000);
      cmd(16'h4000, 16'h0014);
      rd_chk(A_DAT, 32'h0000_0014);
      cmd(16'h5000, 16'h0028);
      rd_chk(A_DAT, 32'h0000_0028);
      cmd(16'h1876, 16'h0000);
      repeat (4) @(posedge clk_i);
      check_eq({31'h0, switch_o}, 32'h1);
   endtask : t_program

   // Without any read command the pulses are measured at once
   task automatic t_hyst;
      pulse_sw(30, 1'b1);
      pulse_sw(42, 1'b0);
      pulse_sw(30, 1'b0);
      pulse_sw(19, 1'b1);
      pulse_sw(10, 1'b1);
   endtask : t_hyst

   task automatic t_read;
      logic [31:0] r;
      wb(1'b1, A_CMD, 16'h0000, r);
      wb(1'b0, A_ECH, 16'h0, r);
      check_eq(r & 32'hFC00, 32'h0);
      check_eq(r, 32'h0000_0200);
      wb(1'b0, A_DAT, 16'h0, r);
      check_rng(r, 9, 11);
      check_rng(r * 32'h2, 18, 22);
   endtask : t_read

   // Output disabled: the relation still runs, the pin stays low
   task automatic t_disable;
      cmd(16'h1856, 16'h0000);
      pulse_sw(42, 1'b0);
      pulse_sw(10, 1'b0);
      rd_chk(A_STA, 32'h0000_0006);
      // Relation 001: count at or above the initial limit
      cmd(16'h1871, 16'h0000);
      pulse_sw(10, 1'b0);
      pulse_sw(25, 1'b1);
      cmd(16'h2800, 16'h0000);
      pulse_sw(10, 1'b0);
      rd_chk(A_STA, 32'h0000_0000);
   endtask : t_disable

   //==========================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_program();
      t_hyst();
      t_read();
      t_disable();
      report_and_stop();
   end

   // Whole run needs some 2300 clocks; over ten times that is a hang
   initial
   begin
      repeat (30000) @(posedge clk_i);
      err_count++;
      report_and_stop();
   end

endmodule : tb_top
